/* File: src/cfgclk_ctrl.sv */
// configuration word loader/decoder and dual clock mode sequencer
`timescale 1ns/1ps
`include "cfgclk_defines.svh"

module cfgclk_ctrl (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // program ROM read port for the configuration word
    output logic [11:0]      o_rom_addr,
    output logic             o_rom_rd,
    input  wire logic [13:0] i_rom_data,
    input  wire logic        i_rom_valid,
    // program readout request from the debug/reader path
    input  wire logic        i_read_req,
    input  wire logic [11:0] i_read_addr,
    output logic             o_read_blocked,
    // clock control from firmware
    input  wire logic        i_slow_enable,
    input  wire logic        i_slow_clock_switch,
    input  wire logic        i_fast_stop,
    input  wire logic        i_timer2_clock_select,
    input  wire logic [1:0]  i_slow_source_type,
    input  wire logic [1:0]  i_fast_rc_freq_select,
    input  wire logic        i_sleep,
    // wake events
    input  wire logic        i_external_interrupt,
    input  wire logic        i_port_b_wakeup,
    input  wire logic        i_wakeup_timer,
    input  wire logic        i_timer2_interrupt,
    // oscillator ticks
    input  wire logic        i_fast_tick,
    input  wire logic        i_slow_tick,
    // decoded configuration
    output logic [13:0]      o_system_config_word,
    output logic             o_cfg_valid,
    output logic             o_readout_guard_n,
    output logic             o_rom_second_half_n,
    output logic [1:0]       o_low_voltage_reset_mode,
    output logic             o_lvr_active,
    output logic [1:0]       o_fast_source_select,
    output logic             o_pin_reset_enable,
    output logic             o_watchdog_reset_enable,
    output logic [4:0]       o_fast_rc_trim,
    output logic [1:0]       o_fast_rc_freq_select,
    output logic [11:0]      o_reset_vector,
    output logic [11:0]      o_int_vector,
    // clock mode results
    output logic [1:0]       o_mode,
    output logic             o_fetch_halt,
    output logic             o_fast_osc_en,
    output logic             o_slow_osc_en,
    output logic [1:0]       o_slow_source_sel,
    output logic             o_cpu_tick,
    output logic             o_periph_tick,
    output logic             o_periph_on_slow,
    output logic             o_timer2_tick,
    output logic             o_timer2_on_fast
);

    typedef struct packed {
        cfgclk_pkg::cfgclk_load_e load;
        cfgclk_pkg::cfgclk_mode_e mode;
        logic [13:0]              cfg;
        logic                     rom_rd;
        logic                     read_blocked;
        logic [1:0]               rc_freq;
        logic [1:0]               slow_sel;
        logic                     fast_osc;
        logic                     slow_osc;
        logic                     lvr_active;
        logic                     cpu_tick;
        logic                     periph_tick;
        logic                     periph_slow;
        logic                     tm2_tick;
        logic                     tm2_fast;
    } cfgclk_ctrl_s;

    cfgclk_ctrl_s st_ff;
    cfgclk_ctrl_s nxt_st;

    logic sw_tick;
    logic sw_on_slow;
    logic running;
    logic loaded;
    logic wake_any;
    logic reuse_on;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic guard_hit(input logic [13:0] cfg, input logic [11:0] addr);
        logic reuse;
        reuse = !cfg[`CFGCLK_BIT_REUSE_N];
        if (cfg[`CFGCLK_BIT_GUARD_N]) begin
            guard_hit = 1'b0;
        end else if (reuse) begin
            guard_hit = (addr < `CFGCLK_RESERVED_FIRST);
        end else begin
            guard_hit = (addr <= `CFGCLK_HALF_LAST);
        end
    endfunction

    // the CPU keeps the fast source until it is told to leave; in SLOW with the
    // fast oscillator stopped the switch can only go back once it runs again
    cfgclk_clk_switch u_switch (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_fast_tick (i_fast_tick),
        .i_slow_tick (i_slow_tick),
        .i_sel_slow  (st_ff.mode == cfgclk_pkg::MODE_SLOW),
        .o_tick      (sw_tick),
        .o_on_slow   (sw_on_slow)
    );

    assign loaded   = (st_ff.load == cfgclk_pkg::LD_DONE);
    assign running  = loaded && (st_ff.mode == cfgclk_pkg::MODE_FAST || st_ff.mode == cfgclk_pkg::MODE_SLOW);
    assign reuse_on = !st_ff.cfg[`CFGCLK_BIT_REUSE_N];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rom_rd = 1'b0;
        wake_any      = i_external_interrupt || i_port_b_wakeup || i_wakeup_timer;

        // word is read once from its fixed address and never written here
        case (st_ff.load)
            cfgclk_pkg::LD_REQ: begin
                nxt_st.rom_rd = 1'b1;
                nxt_st.load   = cfgclk_pkg::LD_WAIT;
            end
            cfgclk_pkg::LD_WAIT: begin
                if (i_rom_valid) begin
                    nxt_st.cfg  = i_rom_data;
                    nxt_st.load = cfgclk_pkg::LD_DONE;
                end
            end
            cfgclk_pkg::LD_DONE: begin
                nxt_st.load = cfgclk_pkg::LD_DONE;
            end
            default: begin
                nxt_st.load = cfgclk_pkg::LD_REQ;
            end
        endcase

        nxt_st.read_blocked = i_read_req && guard_hit(st_ff.cfg, i_read_addr);
        nxt_st.rc_freq      = i_fast_rc_freq_select;
        nxt_st.slow_sel     = i_slow_source_type;

        if (loaded) begin
            case (st_ff.mode)
                cfgclk_pkg::MODE_FAST: begin
                    if (i_sleep) begin
                        if (i_slow_enable && !i_timer2_clock_select) begin
                            nxt_st.mode = cfgclk_pkg::MODE_IDLE;
                        end else begin
                            nxt_st.mode = cfgclk_pkg::MODE_STOP;
                        end
                    end else if (i_slow_clock_switch && i_slow_enable) begin
                        nxt_st.mode = cfgclk_pkg::MODE_SLOW;
                    end
                end
                cfgclk_pkg::MODE_SLOW: begin
                    if (i_sleep) begin
                        if (i_slow_enable && !i_timer2_clock_select) begin
                            nxt_st.mode = cfgclk_pkg::MODE_IDLE;
                        end else begin
                            nxt_st.mode = cfgclk_pkg::MODE_STOP;
                        end
                    end else if (!i_slow_clock_switch && !i_fast_stop) begin
                        nxt_st.mode = cfgclk_pkg::MODE_FAST;
                    end
                end
                cfgclk_pkg::MODE_IDLE: begin
                    if (wake_any || i_timer2_interrupt) begin
                        nxt_st.mode = i_slow_clock_switch ? cfgclk_pkg::MODE_SLOW : cfgclk_pkg::MODE_FAST;
                    end
                end
                cfgclk_pkg::MODE_STOP: begin
                    if (wake_any) begin
                        nxt_st.mode = i_slow_clock_switch ? cfgclk_pkg::MODE_SLOW : cfgclk_pkg::MODE_FAST;
                    end
                end
                default: begin
                    nxt_st.mode = cfgclk_pkg::MODE_FAST;
                end
            endcase
        end

        // oscillator power
        case (st_ff.mode)
            cfgclk_pkg::MODE_FAST: begin
                nxt_st.fast_osc = 1'b1;
                nxt_st.slow_osc = i_slow_enable;
            end
            cfgclk_pkg::MODE_SLOW: begin
                nxt_st.fast_osc = !i_fast_stop;
                nxt_st.slow_osc = 1'b1;
            end
            cfgclk_pkg::MODE_IDLE: begin
                nxt_st.fast_osc = 1'b0;
                nxt_st.slow_osc = 1'b1;
            end
            default: begin
                nxt_st.fast_osc = 1'b0;
                nxt_st.slow_osc = 1'b0;
            end
        endcase

        // cpu and peripheral ticks follow the glitch-free switch output
        nxt_st.cpu_tick    = running && sw_tick;
        nxt_st.periph_tick = running && sw_tick;
        nxt_st.periph_slow = sw_on_slow;

        // timer 2 source
        nxt_st.tm2_fast = (st_ff.mode == cfgclk_pkg::MODE_FAST) && i_timer2_clock_select
                          && !i_slow_clock_switch;
        case (st_ff.mode)
            cfgclk_pkg::MODE_FAST: begin
                nxt_st.tm2_tick = nxt_st.tm2_fast ? i_fast_tick : (i_slow_enable && i_slow_tick);
            end
            cfgclk_pkg::MODE_SLOW,
            cfgclk_pkg::MODE_IDLE: begin
                nxt_st.tm2_tick = i_slow_tick;
            end
            default: begin
                nxt_st.tm2_tick = 1'b0;
            end
        endcase
        if (!loaded) begin
            nxt_st.tm2_tick = 1'b0;
        end

        // 1.5V mode with sleep disable drops out in IDLE and STOP
        nxt_st.lvr_active = !((st_ff.cfg[`CFGCLK_LVR_HI:`CFGCLK_LVR_LO] == cfgclk_pkg::LVR_1V5_WAKE)
                              && (st_ff.mode == cfgclk_pkg::MODE_IDLE || st_ff.mode == cfgclk_pkg::MODE_STOP));
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{load: cfgclk_pkg::LD_REQ, mode: cfgclk_pkg::MODE_FAST, cfg: `CFGCLK_CFG_RESET,
                       rom_rd: 1'b0, read_blocked: 1'b0, rc_freq: 2'b00, slow_sel: 2'b00,
                       fast_osc: 1'b1, slow_osc: 1'b0, lvr_active: 1'b1, cpu_tick: 1'b0,
                       periph_tick: 1'b0, periph_slow: 1'b0, tm2_tick: 1'b0, tm2_fast: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_rom_addr               = `CFGCLK_CFG_ADDR;
    assign o_rom_rd                 = st_ff.rom_rd;
    assign o_read_blocked           = st_ff.read_blocked;
    assign o_system_config_word     = st_ff.cfg;
    assign o_cfg_valid              = loaded;
    assign o_readout_guard_n        = st_ff.cfg[`CFGCLK_BIT_GUARD_N];
    assign o_rom_second_half_n      = st_ff.cfg[`CFGCLK_BIT_REUSE_N];
    assign o_low_voltage_reset_mode = st_ff.cfg[`CFGCLK_LVR_HI:`CFGCLK_LVR_LO];
    assign o_lvr_active             = st_ff.lvr_active;
    assign o_fast_source_select     = st_ff.cfg[`CFGCLK_SRC_HI:`CFGCLK_SRC_LO];
    assign o_pin_reset_enable       = st_ff.cfg[`CFGCLK_BIT_PIN_RST];
    assign o_watchdog_reset_enable  = st_ff.cfg[`CFGCLK_BIT_WDT_RST];
    assign o_fast_rc_trim           = st_ff.cfg[`CFGCLK_TRIM_HI:`CFGCLK_TRIM_LO];
    assign o_fast_rc_freq_select    = st_ff.rc_freq;
    assign o_reset_vector           = reuse_on ? `CFGCLK_RST_VEC_HIGH : `CFGCLK_RST_VEC_LOW;
    assign o_int_vector             = reuse_on ? `CFGCLK_INT_VEC_HIGH : `CFGCLK_INT_VEC_LOW;
    assign o_mode                   = st_ff.mode;
    assign o_fetch_halt             = !running;
    assign o_fast_osc_en            = st_ff.fast_osc;
    assign o_slow_osc_en            = st_ff.slow_osc;
    assign o_slow_source_sel        = st_ff.slow_sel;
    assign o_cpu_tick               = st_ff.cpu_tick;
    assign o_periph_tick            = st_ff.periph_tick;
    assign o_periph_on_slow         = st_ff.periph_slow;
    assign o_timer2_tick            = st_ff.tm2_tick;
    assign o_timer2_on_fast         = st_ff.tm2_fast;

    // ****************************************
    // checks
    // ****************************************
    chk_tm2_fast_sel: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (loaded && st_ff.mode == cfgclk_pkg::MODE_FAST && i_timer2_clock_select && !i_slow_clock_switch)
        |=> o_timer2_on_fast)
        else $error("timer 2 not on fast clock when selected");

    chk_stop_osc_off: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (st_ff.mode == cfgclk_pkg::MODE_STOP) [*2] |-> !o_fast_osc_en && !o_slow_osc_en && !o_timer2_tick)
        else $error("oscillator still powered in stop mode");

    chk_fetch_after_load: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !loaded |-> o_fetch_halt && !o_cpu_tick)
        else $error("fetch allowed before configuration load");

    chk_cfg_stable: assert property (
        @(posedge i_clock) disable iff (i_rst)
        loaded |=> $stable(o_system_config_word))
        else $error("configuration word changed after load");

    chk_readout_guard: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_read_req && !st_ff.cfg[`CFGCLK_BIT_GUARD_N] && i_read_addr <= `CFGCLK_HALF_LAST) |=> o_read_blocked)
        else $error("first half readable while guarded");

    chk_vector_reuse: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !o_rom_second_half_n |-> (o_reset_vector == `CFGCLK_RST_VEC_HIGH) && (o_int_vector == `CFGCLK_INT_VEC_HIGH))
        else $error("vectors not moved in reuse mode");

    chk_idle_entry: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (loaded && running && i_sleep && i_slow_enable && !i_timer2_clock_select)
        |=> (o_mode == cfgclk_pkg::MODE_IDLE) ##1 o_slow_osc_en)
        else $error("sleep with slow clock did not enter idle");

    chk_stop_wake_tm2: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (st_ff.mode == cfgclk_pkg::MODE_STOP && !i_external_interrupt && !i_port_b_wakeup && !i_wakeup_timer)
        |=> (o_mode == cfgclk_pkg::MODE_STOP))
        else $error("stop mode left without a valid wake event");

    chk_reset_fast: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $fell(o_fetch_halt) && !$past(loaded) |-> o_mode == cfgclk_pkg::MODE_FAST)
        else $error("first fetch not in fast mode");

endmodule // cfgclk_ctrl

/* File: src/cfgclk_defines.svh */
// constants for the configuration word decoder and clock mode sequencer
`ifndef CFGCLK_DEFINES_SVH
`define CFGCLK_DEFINES_SVH

// ****************************************
// configuration word location and layout
// ****************************************
`define CFGCLK_CFG_ADDR         12'hffc
`define CFGCLK_CFG_RESET        14'h3fe0
`define CFGCLK_BIT_GUARD_N      13
`define CFGCLK_BIT_REUSE_N      12
`define CFGCLK_LVR_HI           11
`define CFGCLK_LVR_LO           10
`define CFGCLK_SRC_HI           9
`define CFGCLK_SRC_LO           8
`define CFGCLK_BIT_PIN_RST      7
`define CFGCLK_BIT_WDT_RST      6
`define CFGCLK_BIT_TEST         5
`define CFGCLK_TRIM_HI          4
`define CFGCLK_TRIM_LO          0

// ****************************************
// program memory map
// ****************************************
`define CFGCLK_HALF_LAST        12'h7ff
`define CFGCLK_RESERVED_FIRST   12'hffc
`define CFGCLK_RST_VEC_LOW      12'h000
`define CFGCLK_INT_VEC_LOW      12'h001
`define CFGCLK_RST_VEC_HIGH     12'h800
`define CFGCLK_INT_VEC_HIGH     12'h801

`endif

/* File: src/cfgclk_pkg.sv */
// types shared by the configuration decoder and clock mode sequencer
package cfgclk_pkg;

    typedef enum logic [1:0] {
        MODE_FAST = 2'b00,
        MODE_SLOW = 2'b01,
        MODE_IDLE = 2'b10,
        MODE_STOP = 2'b11
    } cfgclk_mode_e;

    typedef enum logic [1:0] {
        LD_REQ  = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } cfgclk_load_e;

    typedef enum logic [1:0] {
        SW_FAST    = 2'b00,
        SW_TO_SLOW = 2'b01,
        SW_SLOW    = 2'b10,
        SW_TO_FAST = 2'b11
    } cfgclk_sw_e;

    // fast source codes of the configuration word
    typedef enum logic [1:0] {
        SRC_EXT_RC   = 2'b00,
        SRC_FAST_RC  = 2'b01,
        SRC_SLOW_XTL = 2'b10,
        SRC_FAST_XTL = 2'b11
    } cfgclk_fast_src_e;

    // low-voltage reset mode codes
    typedef enum logic [1:0] {
        LVR_3V2      = 2'b00,
        LVR_2V3      = 2'b01,
        LVR_1V5_WAKE = 2'b10,
        LVR_1V5      = 2'b11
    } cfgclk_lvr_e;

endpackage

/* File: src/cfgclk_clk_switch.sv */
// glitch-free selection between fast and slow clock enable ticks
`timescale 1ns/1ps
`include "cfgclk_defines.svh"

module cfgclk_clk_switch (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // source ticks
    input  wire logic i_fast_tick,
    input  wire logic i_slow_tick,
    // control
    input  wire logic i_sel_slow,
    // result
    output logic      o_tick,
    output logic      o_on_slow
);

    typedef struct packed {
        cfgclk_pkg::cfgclk_sw_e state;
        logic                   tick;
        logic                   on_slow;
    } cfgclk_sw_s;

    cfgclk_sw_s st_ff;
    cfgclk_sw_s nxt_st;

    // ****************************************
    // switch sequencing
    // ****************************************
    // the first tick of the new source after the old one is dropped is
    // discarded, so the gap before the next passed tick is a full period
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        case (st_ff.state)
            cfgclk_pkg::SW_FAST: begin
                if (i_sel_slow) begin
                    nxt_st.state = cfgclk_pkg::SW_TO_SLOW;
                end else begin
                    nxt_st.tick = i_fast_tick;
                end
            end
            cfgclk_pkg::SW_TO_SLOW: begin
                if (i_slow_tick) begin
                    nxt_st.state   = cfgclk_pkg::SW_SLOW;
                    nxt_st.on_slow = 1'b1;
                end
            end
            cfgclk_pkg::SW_SLOW: begin
                if (!i_sel_slow) begin
                    nxt_st.state = cfgclk_pkg::SW_TO_FAST;
                end else begin
                    nxt_st.tick = i_slow_tick;
                end
            end
            cfgclk_pkg::SW_TO_FAST: begin
                if (i_fast_tick) begin
                    nxt_st.state   = cfgclk_pkg::SW_FAST;
                    nxt_st.on_slow = 1'b0;
                end
            end
            default: begin
                nxt_st.state = cfgclk_pkg::SW_FAST;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{state: cfgclk_pkg::SW_FAST, tick: 1'b0, on_slow: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick    = st_ff.tick;
    assign o_on_slow = st_ff.on_slow;

    // ****************************************
    // checks
    // ****************************************
    // a source change must sit inside a tick-free gap on both sides
    chk_switch_no_tick: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $changed(st_ff.on_slow) |-> !st_ff.tick && !$past(st_ff.tick))
        else $error("tick passed next to a clock source change");

endmodule // cfgclk_clk_switch

/* File: test/cfgclk_osc_rom_model.sv */
// oscillator ticks and program ROM stand-in for the config decoder
`timescale 1ns/1ps
module cfgclk_osc_rom_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // rom side
    input  wire logic        i_rom_rd,
    input  wire logic [11:0] i_rom_addr,
    input  wire logic [13:0] i_word,
    output logic [13:0]      o_rom_data,
    output logic             o_rom_valid,
    // oscillators
    input  wire logic        i_fast_osc_en,
    input  wire logic        i_slow_osc_en,
    output logic             o_fast_tick,
    output logic             o_slow_tick
);
    logic [2:0] div_ff;
    logic       hit;
    assign hit = i_rom_rd && (i_rom_addr == 12'hffc);
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_ff <= 3'h0;
            o_rom_valid <= 1'b0;
            o_rom_data <= 14'h0000;
            o_fast_tick <= 1'b0;
            o_slow_tick <= 1'b0;
        end else begin
            div_ff <= div_ff + 3'h1;
            o_rom_valid <= hit;
            // programmer always writes bit 5 high; released bus shows inverted data
            o_rom_data <= hit ? (i_word | 14'h0020) : ~o_rom_data;
            // a powered-down oscillator gives no ticks
            o_fast_tick <= i_fast_osc_en && div_ff[0];
            o_slow_tick <= i_slow_osc_en && (div_ff == 3'h7);
        end
    end
endmodule // cfgclk_osc_rom_model

/* File: test/testbench.sv */
// self-checking bench for the config decoder and clock modes
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // signals
    // ****************************************
    logic i_clock = 0, i_rst = 1, i_rom_valid, i_read_req = 0, i_sleep = 0, i_fast_tick, i_slow_tick;
    logic i_slow_enable = 0, i_slow_clock_switch = 0, i_fast_stop = 0, i_timer2_clock_select = 0;
    logic i_external_interrupt = 0, i_port_b_wakeup = 0, i_wakeup_timer = 0, i_timer2_interrupt = 0;
    logic [1:0] i_slow_source_type = 2'h2, i_fast_rc_freq_select = 2'h1;
    logic [11:0] i_read_addr = 12'h000, o_rom_addr, o_reset_vector, o_int_vector;
    logic [13:0] i_rom_data, o_system_config_word, word = 14'h3fff;
    logic o_rom_rd, o_read_blocked, o_cfg_valid, o_readout_guard_n, o_rom_second_half_n, o_lvr_active;
    logic o_pin_reset_enable, o_watchdog_reset_enable, o_fetch_halt, o_fast_osc_en, o_slow_osc_en;
    logic o_cpu_tick, o_periph_tick, o_periph_on_slow, o_timer2_tick, o_timer2_on_fast;
    logic [1:0] o_low_voltage_reset_mode, o_fast_source_select, o_fast_rc_freq_select, o_mode, o_slow_source_sel;
    logic [4:0] o_fast_rc_trim;
    logic [11:0] addrs [4] = '{12'h07ff, 12'h0800, 12'h0ffb, 12'h0ffc};
    logic [13:0] words [4] = '{14'h3fff, 14'h05b6, 14'h202a, 14'h1a65};
    int miscompares = 0, tests_run = 0;
    always #20 i_clock = ~i_clock;
    cfgclk_ctrl dut (.i_clock, .i_rst, .o_rom_addr, .o_rom_rd, .i_rom_data, .i_rom_valid, .i_read_req,
        .i_read_addr, .o_read_blocked, .i_slow_enable, .i_slow_clock_switch, .i_fast_stop,
        .i_timer2_clock_select, .i_slow_source_type, .i_fast_rc_freq_select, .i_sleep, .i_external_interrupt,
        .i_port_b_wakeup, .i_wakeup_timer, .i_timer2_interrupt, .i_fast_tick, .i_slow_tick, .o_system_config_word,
        .o_cfg_valid, .o_readout_guard_n, .o_rom_second_half_n, .o_low_voltage_reset_mode, .o_lvr_active,
        .o_fast_source_select, .o_pin_reset_enable, .o_watchdog_reset_enable, .o_fast_rc_trim,
        .o_fast_rc_freq_select, .o_reset_vector, .o_int_vector, .o_mode, .o_fetch_halt, .o_fast_osc_en,
        .o_slow_osc_en, .o_slow_source_sel, .o_cpu_tick, .o_periph_tick, .o_periph_on_slow, .o_timer2_tick,
        .o_timer2_on_fast);
    cfgclk_osc_rom_model partner (.i_clock, .i_rst, .i_rom_rd(o_rom_rd), .i_rom_addr(o_rom_addr), .i_word(word),
        .i_fast_osc_en(o_fast_osc_en), .i_slow_osc_en(o_slow_osc_en), .o_rom_data(i_rom_data),
        .o_rom_valid(i_rom_valid), .o_fast_tick(i_fast_tick), .o_slow_tick(i_slow_tick));
    // ****************************************
    // helpers and scenarios
    // ****************************************
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic load(input logic [13:0] w);
        word = w;
        i_rst = 1;
        step(12);
        chk(o_system_config_word, 14'h3fe0);
        chk({o_mode, o_fetch_halt, o_cfg_valid}, 4'h2);
        i_rst = 0;
        for (int k = 0; k < 20 && o_cfg_valid !== 1'b1; k++) step(1);
        if (o_cfg_valid !== 1'b1) begin
            miscompares++;
            close_out();
        end
        w[5] = 1'b1;
        chk(o_system_config_word, w);
        chk(o_readout_guard_n, w[13]);
        chk(o_rom_second_half_n, w[12]);
        chk(o_low_voltage_reset_mode, w[11:10]);
        chk(o_fast_source_select, w[9:8]);
        chk({o_pin_reset_enable, o_watchdog_reset_enable}, w[7:6]);
        chk(o_fast_rc_trim, w[4:0]);
        chk(o_fast_rc_freq_select, i_fast_rc_freq_select);
        chk(o_reset_vector, w[12] ? 12'h000 : 12'h800);
        chk(o_int_vector, w[12] ? 12'h001 : 12'h801);
        chk(o_fetch_halt, 1'b0);
        // back-to-back readout requests across both half boundaries
        foreach (addrs[k]) begin
            i_read_req = 1;
            i_read_addr = addrs[k];
            step(1);
            chk(o_read_blocked, !w[13] && (addrs[k] <= 12'h7ff || (!w[12] && addrs[k] < 12'hffc)));
        end
        i_read_req = 0;
    endtask
    task automatic sleep_to(input logic [1:0] m);
        i_sleep = 1;
        step(1);
        i_sleep = 0;
        chk({o_mode, o_fetch_halt}, {m, 1'b1});
        step(1);
        chk({o_fast_osc_en, o_slow_osc_en}, {1'b0, m == cfgclk_pkg::MODE_IDLE});
    endtask
    task automatic wake(input logic [3:0] ev, input logic [1:0] m);
        {i_external_interrupt, i_port_b_wakeup, i_wakeup_timer, i_timer2_interrupt} = ev;
        step(1);
        {i_external_interrupt, i_port_b_wakeup, i_wakeup_timer, i_timer2_interrupt} = 4'h0;
        chk(o_mode, m);
    endtask
    task automatic modes();
        int n, p, t;
        i_timer2_clock_select = 1;
        n = 0;
        p = 0;
        t = 0;
        repeat (16) begin
            step(1);
            if (o_cpu_tick === 1'b1) n++;
            if (o_periph_tick === 1'b1) p++;
            if (o_timer2_tick === 1'b1) t++;
        end
        chk(n != 0, 1'b1);
        chk(p != 0, 1'b1);
        chk(t != 0, 1'b1);
        chk({o_timer2_on_fast, o_periph_on_slow}, 2'b10);
        i_slow_enable = 1;
        i_slow_clock_switch = 1;
        i_fast_stop = 1;
        step(1);
        chk(o_mode, cfgclk_pkg::MODE_SLOW);
        // the switch waits for a slow tick before moving over
        step(2);
        for (int k = 0; k < 20 && o_periph_on_slow !== 1'b1; k++) step(1);
        chk({o_periph_on_slow, o_timer2_on_fast, o_fast_osc_en, o_slow_source_sel}, {3'b100, i_slow_source_type});
        i_fast_stop = 0;
        i_slow_clock_switch = 0;
        step(1);
        chk(o_mode, cfgclk_pkg::MODE_FAST);
        // slow clock on but timer 2 on the fast clock still powers everything down
        sleep_to(cfgclk_pkg::MODE_STOP);
        wake(4'h8, cfgclk_pkg::MODE_FAST);
        i_timer2_clock_select = 0;
        step(1);
        sleep_to(cfgclk_pkg::MODE_IDLE);
        chk(o_lvr_active, 1'b0);
        wake(4'h1, cfgclk_pkg::MODE_FAST);
        i_slow_enable = 0;
        for (int k = 0; k < 3; k++) begin
            step(2);
            sleep_to(cfgclk_pkg::MODE_STOP);
            wake(4'h1, cfgclk_pkg::MODE_STOP);
            wake(4'h8 >> k, cfgclk_pkg::MODE_FAST);
        end
    endtask
    initial begin
        foreach (words[k]) load(words[k]);
        modes();
        close_out();
    end
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end
endmodule // testbench
